/* File: src/mode_gate_pkg.sv */
// constants for the mode gated register bank
package mode_gate_pkg;
	localparam int          NUM_OUT        = 6;
	localparam logic [11:0] OFF_MODE_CTRL  = 12'h000;
	localparam logic [11:0] OFF_STATUS     = 12'h004;
	localparam logic [11:0] OFF_OUT_ENABLE = 12'h008;
	localparam logic [11:0] OFF_SPREAD     = 12'h00C;
	localparam logic [11:0] OFF_IN_SELECT  = 12'h010;
	localparam logic [11:0] OFF_DIVIDER0   = 12'h020;
	localparam int          DIV_STRIDE     = 4;
	localparam int          MODE_BIT_ACTIVE = 0;
	localparam int          MODE_BIT_RESET  = 1;
	localparam logic [15:0] DIVIDER_RESET  = 16'h0004;
	localparam logic [5:0]  OE_RESET       = 6'h3F;
	typedef enum logic {MODE_READY, MODE_ACTIVE} mode_t;
endpackage : mode_gate_pkg

/* File: src/clock_out_divider.sv */
// one output clock divider, running only while enabled
`timescale 1ns/10ps
module clock_out_divider
	import mode_gate_pkg::*;
#(
	parameter int WIDTH = 16
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             run,
	input  wire logic [WIDTH-1:0] half_period,
	output logic                  clk_out
);
	typedef struct packed {
		logic [WIDTH-1:0] count;
		logic             level;
	} div_state_t;

	div_state_t state_reg;
	div_state_t state_next;

	always_comb begin
		state_next = state_reg;
		if (!run) begin
			state_next.count = '0;
			state_next.level = 1'b0;
		end else if (state_reg.count + 1'b1 >= half_period) begin
			state_next.count = '0;
			state_next.level = ~state_reg.level;
		end else begin
			state_next.count = state_reg.count + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign clk_out = state_reg.level;
endmodule : clock_out_divider

/* File: src/mode_gated_register_write.sv */
// APB register bank with active/ready write gating for a clock generator
// How it works
// - output clocks toggle only while the mode is active.
// - in active mode, writes to divider registers are dropped.
// - in ready mode, divider registers accept writes.
// - in ready mode every output clock is held low.
// - going back to active restarts dividers with the new divider values.
// - mode, output enable, spread and input select accept writes in any mode.
// - a status register reports active or ready.
// - the mode register selects active or ready or requests a reset.
`timescale 1ns/10ps
module mode_gated_register_write
	import mode_gate_pkg::*;
#(
	parameter int DIV_WIDTH = 16
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic [NUM_OUT-1:0] clk_out,
	output logic             spread_enable,
	output logic             input_select
);
	typedef struct packed {
		mode_t                              mode;
		logic [NUM_OUT-1:0]                 out_enable;
		logic                               spread;
		logic                               in_sel;
		logic [NUM_OUT-1:0][DIV_WIDTH-1:0]  divider;
		logic [31:0]                        rdata;
		logic                               ready;
		logic                               err;
		logic [NUM_OUT-1:0]                 clk;
	} bank_t;

	bank_t bank_reg;
	bank_t bank_next;
	logic [NUM_OUT-1:0] div_clk;

	// one wait state: answer on the access cycle's edge after setup
	wire access = psel && penable && !bank_reg.ready;
	wire wr     = access && pwrite;
	wire rd     = access && !pwrite;

	always_comb begin
		int i;
		logic hit;
		i = 0;
		hit = 1'b0;
		bank_next = bank_reg;
		bank_next.ready = access;
		bank_next.err   = 1'b0;
		bank_next.rdata = 32'h0000_0000;
		// stopped outputs held low outside active mode; registered so
		// the pins never see a glitch from the enable gating
		bank_next.clk = (bank_reg.mode == MODE_ACTIVE) ?
			(div_clk & bank_reg.out_enable) : '0;
		// always writable registers
		if (wr && pstrb[0]) begin
			unique case (paddr)
				OFF_MODE_CTRL: begin
					if (pwdata[MODE_BIT_RESET]) begin
						bank_next.mode       = MODE_ACTIVE;
						bank_next.out_enable = OE_RESET;
						bank_next.spread     = 1'b0;
						bank_next.in_sel     = 1'b0;
						bank_next.divider    = {NUM_OUT{DIV_WIDTH'(DIVIDER_RESET)}};
					end else begin
						bank_next.mode = pwdata[MODE_BIT_ACTIVE] ?
							MODE_ACTIVE : MODE_READY;
					end
				end
				OFF_OUT_ENABLE: bank_next.out_enable = pwdata[NUM_OUT-1:0];
				OFF_SPREAD:     bank_next.spread = pwdata[0];
				OFF_IN_SELECT:  bank_next.in_sel = pwdata[0];
				default: ;
			endcase
		end
		for (i = 0; i < NUM_OUT; i++) begin
			if (paddr == OFF_DIVIDER0 + 12'(i * DIV_STRIDE)) begin
				hit = 1'b1;
				// gated: active mode silently drops the write
				if (wr && bank_reg.mode == MODE_READY) begin
					if (pstrb[0])
						bank_next.divider[i][7:0] = pwdata[7:0];
					if (pstrb[1])
						bank_next.divider[i][15:8] = pwdata[15:8];
				end
				if (rd)
					bank_next.rdata = 32'(bank_reg.divider[i]);
			end
		end
		if (rd) begin
			unique case (paddr)
				OFF_MODE_CTRL:  bank_next.rdata = 32'(bank_reg.mode);
				OFF_STATUS:     bank_next.rdata = 32'(bank_reg.mode);
				OFF_OUT_ENABLE: bank_next.rdata = 32'(bank_reg.out_enable);
				OFF_SPREAD:     bank_next.rdata = 32'(bank_reg.spread);
				OFF_IN_SELECT:  bank_next.rdata = 32'(bank_reg.in_sel);
				default:        bank_next.err = !hit;
			endcase
		end else if (wr) begin
			unique case (paddr)
				OFF_MODE_CTRL, OFF_STATUS, OFF_OUT_ENABLE,
				OFF_SPREAD, OFF_IN_SELECT: ;
				default: bank_next.err = !hit;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bank_reg.mode       <= MODE_ACTIVE;
			bank_reg.out_enable <= OE_RESET;
			bank_reg.spread     <= 1'b0;
			bank_reg.in_sel     <= 1'b0;
			bank_reg.divider    <= {NUM_OUT{DIV_WIDTH'(DIVIDER_RESET)}};
			bank_reg.rdata      <= 32'h0000_0000;
			bank_reg.ready      <= 1'b0;
			bank_reg.err        <= 1'b0;
			bank_reg.clk        <= '0;
		end else begin
			bank_reg <= bank_next;
		end
	end

	// dividers restart from zero on each return to active
	for (genvar g = 0; g < NUM_OUT; g++) begin : g_div
		clock_out_divider #(
			.WIDTH(DIV_WIDTH)
		) u_div (
			.pclk       (pclk),
			.presetn    (presetn),
			.run        (bank_reg.mode == MODE_ACTIVE),
			.half_period(bank_reg.divider[g]),
			.clk_out    (div_clk[g])
		);
	end

	assign prdata        = bank_reg.rdata;
	assign pready        = bank_reg.ready;
	assign pslverr       = bank_reg.err;
	assign clk_out       = bank_reg.clk;
	assign spread_enable = bank_reg.spread;
	assign input_select  = bank_reg.in_sel;

	// named steps of the mode change and of the reset command
	sequence s_ready_then_active;
		bank_reg.mode == MODE_READY ##1 bank_reg.mode == MODE_ACTIVE;
	endsequence

	sequence s_reset_cmd;
		wr && pstrb[0] && paddr == OFF_MODE_CTRL && pwdata[MODE_BIT_RESET];
	endsequence

	a_ready_stops_clk: assert property (
		@(posedge pclk) disable iff (!presetn)
		bank_reg.mode == MODE_READY |=> clk_out == '0)
		else $error("clock output toggled in ready mode");

	a_rise_only_active: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(clk_out[0]) |-> $past(bank_reg.mode) == MODE_ACTIVE)
		else $error("clock output rose outside active mode");

	a_active_blocks_div: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr && bank_reg.mode == MODE_ACTIVE && paddr == OFF_DIVIDER0
		|=> $stable(bank_reg.divider[0]))
		else $error("divider changed by write in active mode");

	a_active_blocks_all: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr && bank_reg.mode == MODE_ACTIVE && paddr != OFF_MODE_CTRL
		|=> $stable(bank_reg.divider))
		else $error("a divider changed in active mode");

	a_ready_takes_div: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr && bank_reg.mode == MODE_READY && paddr == OFF_DIVIDER0
		&& pstrb[0] |=> bank_reg.divider[0][7:0] == $past(pwdata[7:0]))
		else $error("divider write lost in ready mode");

	a_div_read_back: assert property (
		@(posedge pclk) disable iff (!presetn)
		rd && paddr == OFF_DIVIDER0
		|=> prdata == 32'($past(bank_reg.divider[0])))
		else $error("divider read back wrong");

	a_refused_no_err: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr && paddr == OFF_DIVIDER0 |=> pready && !pslverr)
		else $error("refused write did not complete cleanly");

	a_pready_pulse: assert property (
		@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("pready held for more than one cycle");

	a_oe_any_mode: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr && pstrb[0] && paddr == OFF_OUT_ENABLE
		|=> bank_reg.out_enable == $past(pwdata[NUM_OUT-1:0]))
		else $error("output enable write lost");

	a_spread_any_mode: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr && pstrb[0] && paddr == OFF_SPREAD
		|=> spread_enable == $past(pwdata[0]))
		else $error("spread enable write lost");

	a_insel_any_mode: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr && pstrb[0] && paddr == OFF_IN_SELECT
		|=> input_select == $past(pwdata[0]))
		else $error("input select write lost");

	a_status_reads: assert property (
		@(posedge pclk) disable iff (!presetn)
		rd && paddr == OFF_STATUS |=> prdata[0] == $past(bank_reg.mode))
		else $error("status does not show mode");

	a_mode_write: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr && pstrb[0] && paddr == OFF_MODE_CTRL && !pwdata[MODE_BIT_RESET]
		|=> bank_reg.mode == mode_t'($past(pwdata[MODE_BIT_ACTIVE])))
		else $error("mode write not applied");

	a_reset_cmd: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_reset_cmd |=> bank_reg.mode == MODE_ACTIVE
		&& bank_reg.out_enable == OE_RESET && !spread_enable && !input_select
		&& bank_reg.divider[0] == DIV_WIDTH'(DIVIDER_RESET))
		else $error("reset command left a register changed");

	a_active_enables: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_ready_then_active |-> !div_clk[0])
		else $error("divider did not restart on return to active");
endmodule : mode_gated_register_write

/* File: tb/apb_host_model.sv */
// apb host that configures the clock generator registers
`timescale 1ns/10ps
module apb_host_model (
	input  wire logic        pclk,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [11:0] paddr,
	output logic      [31:0] pwdata,
	output logic      [3:0]  pstrb
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		pstrb = 4'h0;
	end
	// one transfer; waits for pready however long the bank takes
	task automatic acc(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= 4'hF;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		// bus idles between transfers so no stray cycle hits a register
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : acc
endmodule : apb_host_model

/* File: tb/mode_gated_register_write_test.sv */
// self-checking bench for the mode gated register bank
`timescale 1ns/10ps
module mode_gated_register_write_test
	import mode_gate_pkg::*;
;
	logic              pclk = 1'b0;
	logic              presetn = 1'b0;
	logic              psel, penable, pwrite;
	logic       [11:0] paddr;
	logic       [31:0] pwdata, prdata, q;
	logic       [3:0]  pstrb;
	logic              pready, pslverr, e;
	logic [NUM_OUT-1:0] clk_out;
	logic              spread_enable, input_select;
	int                bad_count = 0, comparisons = 0, cycles = 0;

	apb_host_model i_apb_host_model (.pclk(pclk), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
	mode_gated_register_write i_mode_gated_register_write (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .clk_out(clk_out),
		.spread_enable(spread_enable), .input_select(input_select));

	always #25 pclk = ~pclk;
	// a hang ends the run as a failure
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			conclude();
		end
	end

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rd(input logic [11:0] a, input logic [31:0] x,
		input logic xe);
		i_apb_host_model.acc(1'b0, a, 32'h0000_0000, q, e);
		if (!xe) chk(q, x);
		chk({31'h0000_0000, e}, {31'h0000_0000, xe});
	endtask : rd
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		i_apb_host_model.acc(1'b1, a, d, q, e);
		chk({31'h0000_0000, e}, 32'h0000_0000);
	endtask : wr
	// edges of one output over 40 cycles: 40 / half period when running
	task automatic toggles(input int b, input logic [31:0] x);
		int n;
		logic p;
		n = 0;
		p = clk_out[b];
		repeat (40) begin
			@(posedge pclk);
			if (clk_out[b] !== p) n++;
			p = clk_out[b];
		end
		chk(32'(n), x);
	endtask : toggles

	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFF_STATUS, 32'h0000_0001, 1'b0);
		rd(OFF_DIVIDER0, {16'h0000, DIVIDER_RESET}, 1'b0);
		wr(OFF_DIVIDER0, 32'h0000_0002);
		rd(OFF_DIVIDER0, {16'h0000, DIVIDER_RESET}, 1'b0);
		wr(OFF_SPREAD, 32'h0000_0001);
		wr(OFF_IN_SELECT, 32'h0000_0001);
		wr(OFF_OUT_ENABLE, 32'h0000_003D);
		rd(OFF_OUT_ENABLE, 32'h0000_003D, 1'b0);
		chk({31'h0000_0000, spread_enable}, 32'h0000_0001);
		chk({31'h0000_0000, input_select}, 32'h0000_0001);
		toggles(1, 32'h0000_0000);
		wr(OFF_MODE_CTRL, 32'h0000_0000);
		rd(OFF_STATUS, 32'h0000_0000, 1'b0);
		toggles(0, 32'h0000_0000);
		wr(OFF_DIVIDER0, 32'h0000_0002);
		rd(OFF_DIVIDER0, 32'h0000_0002, 1'b0);
		wr(OFF_DIVIDER0 + 12'(3 * DIV_STRIDE), 32'h0000_0001);
		rd(OFF_DIVIDER0 + 12'(3 * DIV_STRIDE), 32'h0000_0001, 1'b0);
		wr(OFF_MODE_CTRL, 32'h0000_0001);
		rd(OFF_STATUS, 32'h0000_0001, 1'b0);
		toggles(0, 32'h0000_0014);
		toggles(3, 32'h0000_0028);
		toggles(2, 32'h0000_000A);
		toggles(5, 32'h0000_000A);
		rd(12'h0FC, 32'h0000_0000, 1'b1);
		wr(OFF_MODE_CTRL, 32'h0000_0002);
		repeat (3) @(posedge pclk);
		rd(OFF_DIVIDER0, {16'h0000, DIVIDER_RESET}, 1'b0);
		rd(OFF_OUT_ENABLE, {26'h000_0000, OE_RESET}, 1'b0);
		rd(OFF_STATUS, 32'h0000_0001, 1'b0);
		chk({31'h0000_0000, spread_enable}, 32'h0000_0000);
		chk({31'h0000_0000, input_select}, 32'h0000_0000);
		conclude();
	end
endmodule : mode_gated_register_write_test
